// >>> core/ddrpi_top.sv
`include "ddrpi_regs.svh"

module ddrpi_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	output logic req_ready,
	input wire ddrpi_pkg::ddrpi_req_s req,
	output logic resp_valid,
	output ddrpi_pkg::ddrpi_resp_s resp,
	input wire logic power_down,
	input wire logic mem_clk,
	output logic mem_clk_pos,
	output logic mem_clk_neg,
	output logic mem_clk_en,
	output logic mem_select_n,
	output logic mem_row_strobe_n,
	output logic mem_col_strobe_n,
	output logic mem_write_n,
	output logic [13:0] mem_addr_mux,
	output logic [1:0] mem_bank_sel,
	output logic [1:0] mem_byte_mask,
	input wire logic [15:0] mem_dq_i,
	output logic [15:0] mem_dq_o,
	output logic [15:0] mem_dq_oe,
	input wire logic [1:0] mem_byte_strobe_i,
	output logic [1:0] mem_byte_strobe_o,
	output logic [1:0] mem_byte_strobe_oe
);

	// ----------------------------------------------------------------
	// System side: accept a request, hold it until the link answers
	// ----------------------------------------------------------------
	ddrpi_pkg::ddrpi_req_s hold_reg;
	ddrpi_pkg::ddrpi_resp_s rhold_reg;
	logic busy_reg, req_tgl_reg;
	logic ack_tgl_reg, ack_s1_reg, ack_s2_reg, ack_s3_reg;

	assign req_ready = !busy_reg;

	// Request word stays frozen while busy, so the link reads it safely
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hold_reg <= '0;
			req_tgl_reg <= 1'b0;
		end
		else if (req_valid && req_ready)
		begin
			hold_reg <= req;
			req_tgl_reg <= !req_tgl_reg;
		end
	end

	// Acknowledge toggle crossing back from the link
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_s3_reg <= 1'b0;
		end
		else
		begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
		end
	end

	// Busy flag and answer registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_reg <= 1'b0;
			resp_valid <= 1'b0;
			resp <= '0;
		end
		else
		begin
			resp_valid <= ack_s2_reg != ack_s3_reg;
			if (ack_s2_reg != ack_s3_reg)
			begin
				busy_reg <= 1'b0;
				resp <= rhold_reg;
			end
			else if (req_valid && req_ready)
				busy_reg <= 1'b1;
		end
	end

	chk_req_busy: assert property (@(posedge clk) disable iff (!resetn)
		req_valid && req_ready |=> !req_ready)
		else $error("request port reopened before the answer");

	// ----------------------------------------------------------------
	// Link side: reset release and crossings into the link domain
	// ----------------------------------------------------------------
	logic lrst_s1_reg, link_rstn;
	logic req_s1_reg, req_s2_reg, req_s3_reg, pd_s1_reg, pd_s2_reg;
	logic [1:0] dqs_s1_reg, dqs_s2_reg;

	// Reset enters asynchronously, releases on the link clock
	always_ff @(posedge mem_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lrst_s1_reg <= 1'b0;
			link_rstn <= 1'b0;
		end
		else
		begin
			lrst_s1_reg <= 1'b1;
			link_rstn <= lrst_s1_reg;
		end
	end

	// Request toggle three flops, power-down level and strobe inputs two flops each;
	// the strobe's first flop is on the falling edge further down
	always_ff @(posedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
			pd_s1_reg <= 1'b0;
			pd_s2_reg <= 1'b0;
			dqs_s2_reg <= 2'h0;
		end
		else
		begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
			pd_s1_reg <= power_down;
			pd_s2_reg <= pd_s1_reg;
			dqs_s2_reg <= dqs_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Link side: command sequencer
	// ----------------------------------------------------------------
	ddrpi_pkg::ddrpi_state_e state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic new_req;
	ddrpi_pkg::ddrpi_cmd_s cmd_reg, cmd_next;

	assign new_req = req_s2_reg != req_s3_reg;

	// Power-down is only entered between transfers, never mid-burst
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ddrpi_pkg::ST_IDLE:
				if (new_req && !pd_s2_reg && mem_clk_en)
					state_next = ddrpi_pkg::ST_ACT;
			ddrpi_pkg::ST_ACT:
			begin
				state_next = ddrpi_pkg::ST_GAP;
				cnt_next = `DDRPI_RCD_CYC;
			end
			ddrpi_pkg::ST_GAP:
			begin
				cnt_next = cnt_reg - `DDRPI_CNT_ONE;
				if (cnt_reg == `DDRPI_CNT_ONE)
					state_next = ddrpi_pkg::ST_CMD;
			end
			ddrpi_pkg::ST_CMD:
			begin
				state_next = ddrpi_pkg::ST_DATA;
				cnt_next = hold_reg.write ? `DDRPI_CNT_ZERO : 3'(`DDRPI_CAS_LAT + `DDRPI_RD_PIPE);
			end
			ddrpi_pkg::ST_DATA:
			begin
				cnt_next = cnt_reg - `DDRPI_CNT_ONE;
				if (cnt_reg == `DDRPI_CNT_ZERO)
					state_next = ddrpi_pkg::ST_PRE;
			end
			ddrpi_pkg::ST_PRE:
				state_next = ddrpi_pkg::ST_DONE;
			default:
				state_next = ddrpi_pkg::ST_IDLE;
		endcase
	end

	// Command pins decoded from the state being entered
	always_comb
	begin
		case (state_next)
			ddrpi_pkg::ST_ACT: cmd_next = `DDRPI_CMD_ACT;
			ddrpi_pkg::ST_CMD:
				cmd_next = hold_reg.write ? `DDRPI_CMD_WRITE : `DDRPI_CMD_READ;
			ddrpi_pkg::ST_PRE: cmd_next = `DDRPI_CMD_PRE;
			ddrpi_pkg::ST_IDLE: cmd_next = `DDRPI_CMD_DESEL;
			default: cmd_next = `DDRPI_CMD_NOP;
		endcase
	end

	always_ff @(posedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			state_reg <= ddrpi_pkg::ST_IDLE;
			cnt_reg <= `DDRPI_CNT_ZERO;
			cmd_reg <= `DDRPI_CMD_DESEL;
			mem_addr_mux <= `DDRPI_ADDR_ZERO;
			mem_bank_sel <= 2'h0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
			mem_bank_sel <= hold_reg.bank;
			if (state_next == ddrpi_pkg::ST_ACT)
				mem_addr_mux <= hold_reg.row;
			else if (state_next == ddrpi_pkg::ST_CMD)
				mem_addr_mux <= hold_reg.col;
			else if (state_next == ddrpi_pkg::ST_PRE)
				mem_addr_mux <= 14'(1) << `DDRPI_AP_BIT;
		end
	end

	assign mem_select_n = cmd_reg.select_n;
	assign mem_row_strobe_n = cmd_reg.row_n;
	assign mem_col_strobe_n = cmd_reg.col_n;
	assign mem_write_n = cmd_reg.write_n;

	// Clock forwarded as a pair; enable held low until reset releases
	assign mem_clk_pos = mem_clk;
	assign mem_clk_neg = !mem_clk;

	always_ff @(posedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
			mem_clk_en <= 1'b0;
		else if (state_reg == ddrpi_pkg::ST_IDLE)
			mem_clk_en <= !pd_s2_reg;
	end

	// ----------------------------------------------------------------
	// Link side: write beats on both edges, read capture on both edges
	// ----------------------------------------------------------------
	logic wr_drive_reg;
	logic [15:0] beat0_reg, beat1_reg, beat1_neg_reg;
	logic [1:0] mask0_reg, mask1_reg, mask1_neg_reg;
	logic [15:0] rd_p1_reg, rd_p2_reg, rd_n1_reg, rd_n2_reg;
	logic [1:0] lane_seen_reg;
	logic ack_tgl_int;

	// High half carries beat 0, low half beat 1 from the falling edge
	always_ff @(posedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			wr_drive_reg <= 1'b0;
			beat0_reg <= 16'h0000;
			beat1_reg <= 16'h0000;
			mask0_reg <= 2'h0;
			mask1_reg <= 2'h0;
		end
		else
		begin
			wr_drive_reg <= state_next == ddrpi_pkg::ST_DATA && hold_reg.write;
			beat0_reg <= hold_reg.data[15:0];
			beat1_reg <= hold_reg.data[31:16];
			mask0_reg <= hold_reg.mask[1:0];
			mask1_reg <= hold_reg.mask[3:2];
		end
	end

	// Falling-edge copies, and first flops of the falling-edge capture.
	// Strobes stand high only in the high half, so a rising edge never sees them
	always_ff @(negedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			beat1_neg_reg <= 16'h0000;
			mask1_neg_reg <= 2'h0;
			rd_n1_reg <= 16'h0000;
			dqs_s1_reg <= 2'h0;
		end
		else
		begin
			beat1_neg_reg <= beat1_reg;
			mask1_neg_reg <= mask1_reg;
			rd_n1_reg <= mem_dq_i;
			dqs_s1_reg <= mem_byte_strobe_i;
		end
	end

	assign mem_dq_o = mem_clk ? beat0_reg : beat1_neg_reg;
	assign mem_byte_mask = mem_clk ? mask0_reg : mask1_neg_reg;

	// Each lane: data and strobe enables follow the shared wr_drive_reg; the strobe is wr_drive_reg gated by mem_clk
	genvar ln;
	generate
		for (ln = 0; ln < 2; ln++)
		begin : g_lane
			assign mem_dq_oe[ln*`DDRPI_LANE_W +: `DDRPI_LANE_W] = {`DDRPI_LANE_W{wr_drive_reg}};
			assign mem_byte_strobe_oe[ln] = wr_drive_reg;
			assign mem_byte_strobe_o[ln] = wr_drive_reg && mem_clk;
		end
	endgenerate

	// Read word is sampled at a fixed latency; strobes mark good lanes
	always_ff @(posedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			rd_p1_reg <= 16'h0000;
			rd_p2_reg <= 16'h0000;
			rd_n2_reg <= 16'h0000;
			lane_seen_reg <= 2'h0;
		end
		else
		begin
			rd_p1_reg <= mem_dq_i;
			rd_p2_reg <= rd_p1_reg;
			rd_n2_reg <= rd_n1_reg;
			if (state_reg == ddrpi_pkg::ST_CMD)
				lane_seen_reg <= 2'h0;
			else if (state_reg == ddrpi_pkg::ST_DATA && !wr_drive_reg)
				lane_seen_reg <= lane_seen_reg | dqs_s2_reg;
		end
	end

	// Answer stays frozen in rhold until the next read;
	// beat0 arrives by the falling-edge path, so it fills the low half
	assign ack_tgl_int = ack_tgl_reg;
	always_ff @(posedge mem_clk or negedge link_rstn)
	begin
		if (!link_rstn)
		begin
			ack_tgl_reg <= 1'b0;
			rhold_reg <= '0;
		end
		else if (state_reg == ddrpi_pkg::ST_DONE)
			ack_tgl_reg <= !ack_tgl_int;
		else if (state_reg == ddrpi_pkg::ST_DATA && cnt_reg == `DDRPI_CNT_ZERO && !hold_reg.write)
			rhold_reg <= {rd_p2_reg, rd_n2_reg, lane_seen_reg};
	end

	// ----------------------------------------------------------------
	// Link side checks
	// ----------------------------------------------------------------
	chk_select_idle: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		state_reg == ddrpi_pkg::ST_IDLE |-> mem_select_n)
		else $error("select low while idle");
	chk_act_row: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		state_reg == ddrpi_pkg::ST_ACT |-> !mem_row_strobe_n && mem_col_strobe_n
		&& mem_addr_mux == hold_reg.row && mem_bank_sel == hold_reg.bank)
		else $error("activate command or row address wrong");
	chk_rw_cmd: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		state_reg == ddrpi_pkg::ST_CMD |-> !mem_col_strobe_n && !mem_select_n
		&& mem_write_n == !hold_reg.write && mem_addr_mux == hold_reg.col)
		else $error("read or write command wrong");
	chk_col_seq: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		state_reg == ddrpi_pkg::ST_ACT |-> ##3 !mem_col_strobe_n && mem_row_strobe_n)
		else $error("column command not three cycles after activate");
	chk_dq_release: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		state_reg != ddrpi_pkg::ST_DATA || !hold_reg.write |-> mem_dq_oe == 16'h0000
		&& mem_byte_strobe_oe == 2'h0)
		else $error("pins driven outside a write burst");
	chk_wr_mask: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		wr_drive_reg |-> mask0_reg == hold_reg.mask[1:0] && beat0_reg == hold_reg.data[15:0])
		else $error("lane mask or beat mismatch");
	chk_cke_pd: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		state_reg == ddrpi_pkg::ST_IDLE && pd_s2_reg |=> !mem_clk_en ##1 !new_req
		|| state_reg == ddrpi_pkg::ST_IDLE)
		else $error("clock enable high in power-down");
	chk_clk_pair: assert property (@(posedge mem_clk) disable iff (!link_rstn)
		mem_clk_neg == !mem_clk_pos)
		else $error("clock pair not complementary");

endmodule

// >>> pkg/ddrpi_regs.svh
`ifndef DDRPI_REGS_SVH
`define DDRPI_REGS_SVH

// ----------------------------------------------------------------
// Pin command codes, order {select_n, row_n, col_n, write_n}
// ----------------------------------------------------------------
`define DDRPI_CMD_DESEL 4'hF
`define DDRPI_CMD_NOP 4'h7
`define DDRPI_CMD_ACT 4'h3
`define DDRPI_CMD_READ 4'h5
`define DDRPI_CMD_WRITE 4'h4
`define DDRPI_CMD_PRE 4'h2

// ----------------------------------------------------------------
// Timing in link clock cycles
// ----------------------------------------------------------------
`define DDRPI_RCD_CYC 3'h2
`define DDRPI_CAS_LAT 3'h2
`define DDRPI_RD_PIPE 3'h2
`define DDRPI_CNT_ZERO 3'h0
`define DDRPI_CNT_ONE 3'h1

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DDRPI_AP_BIT 10
`define DDRPI_ADDR_ZERO 14'h0000
`define DDRPI_WORD_ZERO 32'h0000_0000
`define DDRPI_LANE_W 8

`endif

// >>> pkg/ddrpi_pkg.sv
package ddrpi_pkg;

	// Request from the memory subsystem: one 32-bit word, two beats
	typedef struct packed {
		logic write;
		logic [1:0] bank;
		logic [13:0] row;
		logic [13:0] col;
		logic [31:0] data;
		logic [3:0] mask;
	} ddrpi_req_s;

	// Answer: read word and which lanes saw their strobe
	typedef struct packed {
		logic [31:0] data;
		logic [1:0] lane_ok;
	} ddrpi_resp_s;

	// Command pins, active low
	typedef struct packed {
		logic select_n;
		logic row_n;
		logic col_n;
		logic write_n;
	} ddrpi_cmd_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACT,
		ST_GAP,
		ST_CMD,
		ST_DATA,
		ST_PRE,
		ST_DONE
	} ddrpi_state_e;

endpackage

// >>> bench/ddrpi_mem_model.sv
`include "ddrpi_regs.svh"

// ----------------------------------------------------------------
// Behavioural memory device on the far side of the pins
// ----------------------------------------------------------------
module ddrpi_mem_model (
	input wire logic mem_clk,
	input wire logic [1:0] strobe_en,
	input wire ddrpi_pkg::ddrpi_cmd_s cmd,
	input wire logic [1:0] bank,
	input wire logic [13:0] addr,
	input wire logic [15:0] dq_o,
	input wire logic [15:0] dq_oe,
	input wire logic [1:0] mask,
	output logic [15:0] dq_drv,
	output logic [1:0] dqs_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [0:63];
	logic [31:0] word;
	logic [15:0] b0, b1;
	logic [1:0] m0, m1;
	logic [5:0] wkey;
	logic drv;
	int rd_left;

	initial
	begin
		foreach (mem[i]) mem[i] = 32'h0000_0000;
		word = 32'h0000_0000;
		drv = 1'b0;
		rd_left = 0;
	end

	// Decode mid-cycle, when the registered command pins have settled
	always @(negedge mem_clk)
	begin
		if (cmd === `DDRPI_CMD_READ)
		begin
			word = mem[{bank, addr[3:0]}];
			rd_left = 7; // Window covers the fixed capture point
		end
		else if (rd_left > 0)
			rd_left--;
		if (cmd === `DDRPI_CMD_WRITE)
			wkey = {bank, addr[3:0]};
		drv = (rd_left > 0);
	end

	// Beat0 in the high half, beat1 in the low half; set mask = lane kept
	// Enable looked at mid-phase, never in the step of the edge that moves it
	always @(posedge mem_clk)
	begin
		#8;
		if (dq_oe != 16'h0000)
		begin
			b0 = dq_o;
			m0 = mask;
			#16;
			b1 = dq_o;
			m1 = mask;
			for (int l = 0; l < 2; l++)
			begin
				if (!m0[l]) mem[wkey][l*8 +: 8] = b0[l*8 +: 8];
				if (!m1[l]) mem[wkey][16 + l*8 +: 8] = b1[l*8 +: 8];
			end
		end
	end

	// Released lines show the inverse of the last beat, never a held value
	// Outputs lag each edge like an access time, so no capture races its change
	assign #4 dq_drv = drv ? (mem_clk ? word[15:0] : word[31:16]) : ~word[31:16];
	assign #4 dqs_drv = drv ? ({2{mem_clk}} & strobe_en) : 2'b00;
endmodule

// >>> bench/test_ddrpi_top.sv
`include "ddrpi_regs.svh"

module test_ddrpi_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, resetn, req_valid, req_ready, resp_valid, power_down, mem_clk;
	logic clk_pos, clk_neg, cke;
	ddrpi_pkg::ddrpi_req_s req;
	ddrpi_pkg::ddrpi_resp_s resp;
	ddrpi_pkg::ddrpi_cmd_s cmd;
	logic [13:0] addr;
	logic [1:0] bank, mask, dqs_o, dqs_oe, dqs_m, dqs_i, strobe_en;
	logic [15:0] dq_o, dq_oe, dq_m, dq_i;
	logic [19:0] seen [$];
	int err_total, n_tests, cyc;

	// Wire level from both parties' drivers, picked by the controller's enables
	assign dq_i = (dq_o & dq_oe) | (dq_m & ~dq_oe);
	assign dqs_i = (dqs_o & dqs_oe) | (dqs_m & ~dqs_oe);

	ddrpi_top dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .resp_valid(resp_valid), .resp(resp), .power_down(power_down),
		.mem_clk(mem_clk), .mem_clk_pos(clk_pos), .mem_clk_neg(clk_neg), .mem_clk_en(cke),
		.mem_select_n(cmd.select_n), .mem_row_strobe_n(cmd.row_n),
		.mem_col_strobe_n(cmd.col_n), .mem_write_n(cmd.write_n), .mem_addr_mux(addr),
		.mem_bank_sel(bank), .mem_byte_mask(mask), .mem_dq_i(dq_i), .mem_dq_o(dq_o),
		.mem_dq_oe(dq_oe), .mem_byte_strobe_i(dqs_i), .mem_byte_strobe_o(dqs_o),
		.mem_byte_strobe_oe(dqs_oe));

	ddrpi_mem_model mdl (.mem_clk(clk_pos), .strobe_en(strobe_en), .cmd(cmd), .bank(bank),
		.addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .mask(mask), .dq_drv(dq_m),
		.dqs_drv(dqs_m));

	// ----------------------------------------------------------------
	// Clocks, timeout and pin monitors
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Link clock starts off phase so its edges drift against clk
	initial
	begin
		mem_clk = 1'b0;
		#3.3;
		forever #16 mem_clk = ~mem_clk;
	end

	// Ceiling well above the handful of accesses
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			print_verdict;
		end
	end

	// Log every real command mid-cycle; check the bus is free while the memory drives
	always @(negedge mem_clk)
	begin
		if (cmd !== `DDRPI_CMD_NOP && cmd !== `DDRPI_CMD_DESEL) seen.push_back({cmd, bank, addr});
		if (mdl.drv) chk("dq released", 32'h0, {dq_oe, dqs_oe});
	end

	// Pair and write strobes checked away from the edge
	always @(mem_clk)
	begin
		#2;
		chk("clock pair", {mem_clk, ~mem_clk}, {clk_pos, clk_neg});
		if (dqs_oe === 2'b11) chk("write strobe", {2{mem_clk}}, dqs_o);
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic access(input logic wr, input logic [1:0] bk, input logic [13:0] row,
		input logic [13:0] col, input logic [31:0] data, input logic [3:0] msk);
		int n;
		logic [3:0] rw_cmd;
		n = 0;
		rw_cmd = wr ? `DDRPI_CMD_WRITE : `DDRPI_CMD_READ;
		@(negedge clk);
		req = '{wr, bk, row, col, data, msk};
		req_valid = 1'b1;
		seen.delete();
		while (req_ready !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (resp_valid !== 1'b1 && n < 500)
		begin
			@(negedge clk);
			n++;
		end
		chk("answer in time", 1, n < 500);
		chk("command count", 3, seen.size());
		if (seen.size() == 3)
		begin
			chk("activate", {`DDRPI_CMD_ACT, bk, row}, seen[0]);
			chk("column cmd", {rw_cmd, bk, col}, seen[1]);
			chk("precharge", {`DDRPI_CMD_PRE, 1'b1}, {seen[2][19:16], seen[2][`DDRPI_AP_BIT]});
		end
	endtask

	task automatic print_verdict;
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_word;
		access(1'b1, 2'h2, 14'h1234, 14'h0005, 32'hA5C3_1E69, 4'h0);
		access(1'b0, 2'h2, 14'h1234, 14'h0005, 32'h0000_0000, 4'h0);
		chk("read word", 32'hA5C3_1E69, resp.data);
		chk("lane flags", 2'b11, resp.lane_ok);
	endtask

	// Lane 0 masked on both beats keeps its old bytes
	task automatic t_mask;
		access(1'b1, 2'h2, 14'h1234, 14'h0005, 32'h0F0F_F0F0, 4'b0101);
		access(1'b0, 2'h2, 14'h1234, 14'h0005, 32'h0000_0000, 4'h0);
		chk("masked word", 32'h0FC3_F069, resp.data);
	endtask

	// Memory withholds the upper lane strobe
	task automatic t_strobe;
		strobe_en = 2'b01;
		access(1'b0, 2'h1, 14'h3FFF, 14'h0003, 32'h0000_0000, 4'h0);
		chk("unwritten word", 32'h0, resp.data);
		chk("lane flags", 2'b01, resp.lane_ok);
		strobe_en = 2'b11;
	endtask

	task automatic t_power;
		@(negedge clk);
		power_down = 1'b1;
		repeat (50) @(negedge clk);
		chk("clock enable down", 0, cke);
		power_down = 1'b0;
		repeat (50) @(negedge clk);
		chk("clock enable up", 1, cke);
	endtask

	initial
	begin
		resetn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		power_down = 1'b0;
		strobe_en = 2'b11;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (20) @(negedge clk);
		chk("reset pins", 32'h1, {cke, dq_oe, dqs_oe, cmd.select_n});
		resetn = 1'b1;
		repeat (20) @(negedge clk);
		chk("clock enable", 1, cke);
		t_word;
		t_mask;
		t_strobe;
		t_power;
		print_verdict;
	end
endmodule
